// ===== rtl/dic_top.sv
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module dic_top import dic_pkg::*; #(
    parameter int SCAN_PERIOD = SCAN_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,

    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,

    // Measured field voltages, one word per channel, 0.1 V units
    input wire logic [CHANNELS*VOLT_W-1:0] chan_volt_in,

    // Conditioned states and interrupt
    output logic [CHANNELS-1:0] chan_state,
    output logic irq
);

    // ------------------------------------------------------------
    // Field voltage synchroniser
    // ------------------------------------------------------------
    // The words come from another domain; a value torn across a
    // change settles by the next scan, which is 5 ms away.
    logic [CHANNELS*VOLT_W-1:0] volt_s1_r;
    logic [CHANNELS*VOLT_W-1:0] volt_s2_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            volt_s1_r <= '0;
            volt_s2_r <= '0;
        end else begin
            volt_s1_r <= chan_volt_in;
            volt_s2_r <= volt_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Scan timebase
    // ------------------------------------------------------------
    logic tick;

    dic_scan_tick #(
        .PERIOD(SCAN_PERIOD)
    ) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [3:0] ch_sel;
    logic [4:0] ch_ofs;
    logic ch_hit;
    logic [2:0] ch_idx;

    assign ch_sel = reg_addr[ADDR_W-1:CH_SHIFT];
    assign ch_ofs = reg_addr[CH_SHIFT-1:0];
    assign ch_hit = (ch_sel != 4'h0) && (ch_sel <= 4'(CHANNELS));
    assign ch_idx = 3'(ch_sel - 4'h1);

    // ------------------------------------------------------------
    // Settings held per channel, plus the counter clear strobes and the numbering base
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] pol_r, pol_nxt;
    logic [CHANNELS-1:0] alt_r, alt_nxt;
    logic [VOLT_W-1:0] on_r [CHANNELS];
    logic [VOLT_W-1:0] on_nxt [CHANNELS];
    logic [VOLT_W-1:0] off_r [CHANNELS];
    logic [VOLT_W-1:0] off_nxt [CHANNELS];
    logic [DLY_W-1:0] rise_r [CHANNELS];
    logic [DLY_W-1:0] rise_nxt [CHANNELS];
    logic [DLY_W-1:0] fall_r [CHANNELS];
    logic [DLY_W-1:0] fall_nxt [CHANNELS];
    logic [CHANNELS-1:0] clr_r, clr_nxt;
    logic [15:0] base_r, base_nxt;
    logic [VOLT_W-1:0] wr_volt;
    logic [DLY_W-1:0] wr_dly;

    // Out-of-range writes are clamped so the block never runs on a
    // setting that the product cannot represent.
    always_comb begin
        wr_volt = reg_wdata[VOLT_W-1:0];
        if (reg_wdata[31:VOLT_W] != '0) begin
            wr_volt = '1;
        end
        wr_dly = reg_wdata[DLY_W-1:0];
        if (reg_wdata > 32'(DLY_MAX_MS)) begin
            wr_dly = DLY_MAX_MS;
        end
    end

    always_comb begin
        pol_nxt = pol_r;
        alt_nxt = alt_r;
        on_nxt = on_r;
        off_nxt = off_r;
        rise_nxt = rise_r;
        fall_nxt = fall_r;
        clr_nxt = '0;
        base_nxt = base_r;
        if (reg_wr && ch_hit) begin
            unique case (ch_ofs)
                CFG_OFS: begin
                    pol_nxt[ch_idx] = reg_wdata[CFG_POL_BIT];
                    alt_nxt[ch_idx] = reg_wdata[CFG_AC_BIT];
                end
                ON_OFS: begin
                    on_nxt[ch_idx] = wr_volt;
                end
                OFF_OFS: begin
                    off_nxt[ch_idx] = wr_volt;
                    if (wr_volt < OFF_LEVEL_MIN) begin
                        off_nxt[ch_idx] = OFF_LEVEL_MIN;
                    end else if (wr_volt > OFF_LEVEL_MAX) begin
                        off_nxt[ch_idx] = OFF_LEVEL_MAX;
                    end
                end
                RISE_OFS: begin
                    rise_nxt[ch_idx] = wr_dly;
                end
                FALL_OFS: begin
                    fall_nxt[ch_idx] = wr_dly;
                end
                default: begin
                end
            endcase
        end
        if (reg_wr && reg_addr == CNT_CLR_OFS) begin
            clr_nxt = reg_wdata[CHANNELS-1:0];
        end
        if (reg_wr && reg_addr == BASE_OFS) begin
            base_nxt = reg_wdata[15:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pol_r <= '0;
            alt_r <= '0;
            clr_r <= '0;
            base_r <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                on_r[i] <= ON_LEVEL_RST;
                off_r[i] <= OFF_LEVEL_RST;
                rise_r[i] <= DLY_RST;
                fall_r[i] <= DLY_RST;
            end
        end else begin
            pol_r <= pol_nxt;
            alt_r <= alt_nxt;
            clr_r <= clr_nxt;
            base_r <= base_nxt;
            on_r <= on_nxt;
            off_r <= off_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    // ------------------------------------------------------------
    // Channel instances
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] st;
    logic [CNT_W-1:0] cnt [CHANNELS];
    logic [VOLT_W-1:0] vnow [CHANNELS];

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        dic_channel u_ch (
            .mclk(mclk),
            .rst_n(rst_n),
            .tick(tick),
            .volt_in(volt_s2_r[g*VOLT_W +: VOLT_W]),
            .polarity_nc(pol_r[g]),
            .alt_mode(alt_r[g]),
            .on_level(on_r[g]),
            .off_level(off_r[g]),
            .rise_dly(rise_r[g]),
            .fall_dly(fall_r[g]),
            .cnt_clr(clr_r[g]),
            .state(st[g]),
            .count(cnt[g]),
            .volt_now(vnow[g])
        );
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Low byte flags a rise of each channel, high byte a fall.
    logic [CHANNELS-1:0] st_d_r;
    logic [2*CHANNELS-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic [2*CHANNELS-1:0] ev;
    logic irq_r, irq_nxt;

    assign ev = {st_d_r & ~st, st & ~st_d_r};

    always_comb begin
        ist_nxt = ist_r;
        imask_nxt = imask_r;
        if (reg_rd && reg_addr == IRQ_STAT_OFS) begin
            ist_nxt = '0;
        end
        // An event in the clearing cycle survives the clear.
        ist_nxt = ist_nxt | ev;
        if (reg_wr && reg_addr == IRQ_MASK_OFS) begin
            imask_nxt = reg_wdata[2*CHANNELS-1:0];
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_d_r <= '0;
            ist_r <= '0;
            imask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            st_d_r <= st;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdata_r, rdata_nxt;

    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            if (ch_hit) begin
                unique case (ch_ofs)
                    CFG_OFS: begin
                        rdata_nxt[CFG_POL_BIT] = pol_r[ch_idx];
                        rdata_nxt[CFG_AC_BIT] = alt_r[ch_idx];
                    end
                    ON_OFS: begin
                        rdata_nxt = 32'(on_r[ch_idx]);
                    end
                    OFF_OFS: begin
                        rdata_nxt = 32'(off_r[ch_idx]);
                    end
                    RISE_OFS: begin
                        rdata_nxt = 32'(rise_r[ch_idx]);
                    end
                    FALL_OFS: begin
                        rdata_nxt = 32'(fall_r[ch_idx]);
                    end
                    COUNT_OFS: begin
                        rdata_nxt = cnt[ch_idx];
                    end
                    VOLT_OFS: begin
                        rdata_nxt = 32'(vnow[ch_idx]);
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (reg_addr)
                    STATE_OFS: begin
                        rdata_nxt = 32'(st);
                    end
                    IRQ_STAT_OFS: begin
                        rdata_nxt = 32'(ist_r);
                    end
                    IRQ_MASK_OFS: begin
                        rdata_nxt = 32'(imask_r);
                    end
                    BASE_OFS: begin
                        rdata_nxt = 32'(base_r);
                    end
                    FIRST_NUM_OFS: begin
                        rdata_nxt = 32'(base_r) + 32'h00000001;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign chan_state = st;
    assign irq = irq_r;

endmodule : dic_top

// ===== rtl/dic_pkg.sv
package dic_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int CHANNELS = 8;
    localparam int VOLT_W = 12;
    localparam int DLY_W = 21;
    localparam int TMR_W = 22;
    localparam int CNT_W = 32;
    localparam int CLK_HZ = 100_000_000;
    localparam int SCAN_MS = 5;
    localparam int SCAN_CYCLES = SCAN_MS * (CLK_HZ / 1000);
    localparam int AC_EXTRA_MS = 30;
    localparam logic [VOLT_W-1:0] AC_DIVISOR = 12'h00a;
    localparam logic [DLY_W-1:0] DLY_MAX_MS = 21'h1b7740;

    // ------------------------------------------------------------
    // Reset values and release level limits
    // ------------------------------------------------------------
    localparam logic [VOLT_W-1:0] ON_LEVEL_RST = 12'h370;
    localparam logic [VOLT_W-1:0] OFF_LEVEL_RST = 12'h258;
    localparam logic [VOLT_W-1:0] OFF_LEVEL_MIN = 12'h064;
    localparam logic [VOLT_W-1:0] OFF_LEVEL_MAX = 12'h7d0;
    localparam logic [DLY_W-1:0] DLY_RST = 21'h000000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam logic [ADDR_W-1:0] STATE_OFS = 9'h000;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 9'h004;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 9'h008;
    localparam logic [ADDR_W-1:0] CNT_CLR_OFS = 9'h00c;
    localparam logic [ADDR_W-1:0] BASE_OFS = 9'h010;
    localparam logic [ADDR_W-1:0] FIRST_NUM_OFS = 9'h014;
    localparam int CH_SHIFT = 5;
    localparam logic [4:0] CFG_OFS = 5'h00;
    localparam logic [4:0] ON_OFS = 5'h04;
    localparam logic [4:0] OFF_OFS = 5'h08;
    localparam logic [4:0] RISE_OFS = 5'h0c;
    localparam logic [4:0] FALL_OFS = 5'h10;
    localparam logic [4:0] COUNT_OFS = 5'h14;
    localparam logic [4:0] VOLT_OFS = 5'h18;
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_AC_BIT = 1;

endpackage : dic_pkg

// ===== rtl/dic_scan_tick.sv
`timescale 1ns/10ps
module dic_scan_tick import dic_pkg::*; #(
    parameter int PERIOD = SCAN_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Scan strobe
    output logic tick
);

    logic [31:0] div_r;
    logic [31:0] div_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        div_nxt = div_r + 32'h00000001;
        if (div_r == 32'(PERIOD - 1)) begin
            div_nxt = 32'h00000000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : dic_scan_tick

// ===== rtl/dic_channel.sv
`timescale 1ns/10ps
module dic_channel import dic_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Scan strobe and synchronised measurement
    input wire logic tick,
    input wire logic [VOLT_W-1:0] volt_in,
    // Settings
    input wire logic polarity_nc,
    input wire logic alt_mode,
    input wire logic [VOLT_W-1:0] on_level,
    input wire logic [VOLT_W-1:0] off_level,
    input wire logic [DLY_W-1:0] rise_dly,
    input wire logic [DLY_W-1:0] fall_dly,
    input wire logic cnt_clr,
    // Results
    output logic state,
    output logic [CNT_W-1:0] count,
    output logic [VOLT_W-1:0] volt_now
);

    logic raw_r, raw_nxt, state_r, state_nxt, act;
    logic inc;
    logic [VOLT_W-1:0] volt_r, volt_nxt, off_eff;
    logic [TMR_W-1:0] tmr_r, tmr_nxt, target;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;

    always_comb begin
        volt_nxt = volt_r;
        raw_nxt = raw_r;
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        cnt_nxt = cnt_r;
        inc = 1'b0;
        off_eff = alt_mode ? on_level / AC_DIVISOR : off_level;
        target = TMR_W'(rise_dly);
        if (state_r) begin
            target = TMR_W'(fall_dly)
                + (alt_mode ? TMR_W'(AC_EXTRA_MS) : '0);
        end
        if (tick) begin
            volt_nxt = volt_in;
            if (volt_in > on_level) begin
                raw_nxt = 1'b1;
            end else if (volt_in < off_eff) begin
                raw_nxt = 1'b0;
            end
        end
        act = polarity_nc ? ~raw_nxt : raw_nxt;
        if (tick) begin
            if (act == state_r) begin
                tmr_nxt = '0;
            end else if (tmr_r >= target) begin
                state_nxt = act;
                tmr_nxt = '0;
                inc = act;
            end else begin
                tmr_nxt = tmr_r + TMR_W'(SCAN_MS);
            end
        end
        if (inc) begin
            cnt_nxt = cnt_r + 32'h00000001;
        end
        if (cnt_clr) begin
            cnt_nxt = {31'h00000000, inc};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            volt_r <= '0;
            raw_r <= 1'b0;
            state_r <= 1'b0;
            tmr_r <= '0;
            cnt_r <= '0;
        end else begin
            volt_r <= volt_nxt;
            raw_r <= raw_nxt;
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign state = state_r;
    assign count = cnt_r;
    assign volt_now = volt_r;

endmodule : dic_channel

// ===== test/dic_field_model.sv
`timescale 1ns/10ps
module dic_field_model import dic_pkg::*; (
    // Field voltages toward the card, 0.1 V units
    output logic [CHANNELS*VOLT_W-1:0] chan_volt_in
);
    // ------------------------------------------------------------
    // Contact levels
    // ------------------------------------------------------------
    // The bench moves a level right after a clock edge; the card
    // synchronises it, so no phase relation to the scan is assumed.
    logic [VOLT_W-1:0] lvl [CHANNELS];
    initial begin
        foreach (lvl[i]) lvl[i] = 12'h000;
    end
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            chan_volt_in[i*VOLT_W +: VOLT_W] = lvl[i];
        end
    end
endmodule : dic_field_model

// ===== test/dic_top_asserts.sv
`timescale 1ns/10ps
module dic_top_asserts import dic_pkg::*; #(
    parameter int SCAN_PERIOD = SCAN_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Field side and interrupt
    input wire logic [CHANNELS*VOLT_W-1:0] chan_volt_in,
    input wire logic [CHANNELS-1:0] chan_state,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Scan phase and base mirror
    // ------------------------------------------------------------
    logic [31:0] phase_r, phase_nxt;
    logic [15:0] base_r, base_nxt;
    logic ch_rd;
    assign ch_rd = reg_rd && reg_addr >= 9'h020 && reg_addr < 9'h120;
    always_comb begin
        phase_nxt = phase_r + 32'h1;
        if (phase_r == 32'(SCAN_PERIOD - 1)) phase_nxt = 32'h0;
        base_nxt = base_r;
        if (reg_wr && reg_addr == BASE_OFS) base_nxt = reg_wdata[15:0];
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_r <= 32'h0;
            base_r <= 16'h0000;
        end else begin
            phase_r <= phase_nxt;
            base_r <= base_nxt;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr == 9'h1fc |=> reg_rdata == 32'h0)
        else $error("unmapped read returned nonzero");
    first_num_a: assert property (
        reg_rd && reg_addr == FIRST_NUM_OFS
        |=> reg_rdata == {16'h0000, base_r} + 32'h1)
        else $error("first channel number is not base plus one");
    state_rd_a: assert property (
        reg_rd && reg_addr == STATE_OFS
        |=> reg_rdata == {24'h0, $past(chan_state)})
        else $error("state word differs from channel states");
    quiet_reset_a: assert property (
        $rose(rst_n) |-> (chan_state == 8'h00) [*8])
        else $error("channel state moved before first scan");
    tick_align_a: assert property (
        $changed(chan_state)
        |-> phase_r < 32'h4 || phase_r > 32'(SCAN_PERIOD - 4))
        else $error("channel state changed away from a scan tick");
    mask_off_a: assert property (
        reg_wr && reg_addr == IRQ_MASK_OFS && reg_wdata[15:0] == 16'h0
        ##1 !reg_wr [*2] |-> !irq)
        else $error("interrupt high with every source masked");
    volt_width_a: assert property (
        ch_rd && reg_addr[4:0] == VOLT_OFS |=> reg_rdata[31:12] == 20'h0)
        else $error("voltage reading wider than its field");
    off_range_a: assert property (
        ch_rd && reg_addr[4:0] == OFF_OFS
        |=> reg_rdata >= 32'h64 && reg_rdata <= 32'h7d0)
        else $error("release level outside its range");
endmodule : dic_top_asserts

bind dic_top dic_top_asserts #(.SCAN_PERIOD(SCAN_PERIOD)) i_dic_top_asserts (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .chan_volt_in(chan_volt_in),
    .chan_state(chan_state),
    .irq(irq)
);

// ===== test/dic_top_tb.sv
`timescale 1ns/10ps
module dic_top_tb import dic_pkg::*; ;
    // A short scan keeps the run small; every state check waits whole scans.
    localparam int P = 20;
    logic mclk, rst_n, reg_wr, reg_rd, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [CHANNELS*VOLT_W-1:0] chan_volt_in;
    logic [CHANNELS-1:0] chan_state;
    int fails, cmp_count;

    dic_top #(.SCAN_PERIOD(P)) i_dic_top (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chan_volt_in(chan_volt_in),
        .chan_state(chan_state), .irq(irq));
    dic_field_model i_dic_field_model (.chan_volt_in(chan_volt_in));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [ADDR_W-1:0] ca(int n, logic [4:0] o);
        return 9'(32 * (n + 1)) | {4'h0, o};
    endfunction : ca
    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e, bit chk = 1);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        if (chk) check(reg_rdata, e);
    endtask : rd
    task automatic all(logic [VOLT_W-1:0] v);
        @(posedge mclk);
        for (int i = 0; i < CHANNELS; i++) begin
            i_dic_field_model.lvl[i] <= v;
        end
    endtask : all
    task automatic st(int n, logic [7:0] e);
        repeat (n * P) @(posedge mclk);
        #1 check({24'h0, chan_state}, {24'h0, e});
    endtask : st
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        #100000;
        fails++;
        conclude();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 32'h0;
        fails = 0;
        cmp_count = 0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (int n = 0; n < CHANNELS; n++) begin
            rd(ca(n, CFG_OFS), 32'h0);
            rd(ca(n, ON_OFS), 32'h370);
            rd(ca(n, OFF_OFS), 32'h258);
            rd(ca(n, RISE_OFS), 32'h0);
            rd(ca(n, FALL_OFS), 32'h0);
            rd(ca(n, COUNT_OFS), 32'h0);
        end
        rd(FIRST_NUM_OFS, 32'h1);
        rd(STATE_OFS, 32'h0);
        $display("test defaults done");
        wr(ca(2, ON_OFS), 32'h3e8);
        wr(ca(1, CFG_OFS), 32'h1);
        wr(ca(3, RISE_OFS), 32'h14);
        wr(ca(3, FALL_OFS), 32'ha);
        wr(ca(4, CFG_OFS), 32'h2);
        st(3, 8'h02);
        all(12'h384);
        st(3, 8'hf1);
        st(4, 8'hf9);
        all(12'h2bc);
        st(3, 8'hf9);
        all(12'h1f4);
        st(1, 8'h1a);
        st(4, 8'h12);
        all(12'h032);
        st(5, 8'h12);
        st(4, 8'h02);
        $display("test thresholds and delays done");
        rd(ca(1, COUNT_OFS), 32'h2);
        wr(CNT_CLR_OFS, 32'h1);
        rd(ca(0, COUNT_OFS), 32'h0);
        rd(ca(1, COUNT_OFS), 32'h2);
        rd(ca(0, VOLT_OFS), 32'h32);
        rd(ca(2, ON_OFS), 32'h3e8);
        wr(ca(5, OFF_OFS), 32'h5);
        rd(ca(5, OFF_OFS), 32'h64);
        wr(ca(5, OFF_OFS), 32'hfff);
        rd(ca(5, OFF_OFS), 32'h7d0);
        rd(9'h1fc, 32'h0);
        wr(9'h1fc, 32'hffff);
        wr(BASE_OFS, 32'h10);
        rd(FIRST_NUM_OFS, 32'h11);
        $display("test counters and map done");
        rd(IRQ_STAT_OFS, 32'h0, 0);
        wr(IRQ_MASK_OFS, 32'h1);
        all(12'h384);
        st(3, 8'hf1);
        check({31'h0, irq}, 32'h1);
        rd(IRQ_STAT_OFS, 32'h2f1);
        repeat (2) @(posedge mclk);
        #1 check({31'h0, irq}, 32'h0);
        st(4, 8'hf9);
        check({31'h0, irq}, 32'h0);
        // Unmasking a pending rise raises the line, masking drops it.
        wr(IRQ_MASK_OFS, 32'h8);
        #1 check({31'h0, irq}, 32'h1);
        wr(IRQ_MASK_OFS, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        rd(IRQ_STAT_OFS, 32'h8);
        $display("test interrupt done");
        conclude();
    end
endmodule : dic_top_tb
